// file: src/cache_bus_if.sv
`timescale 1ns/1ps
`include "cache_bus_params.svh"
// Function
// - one 32-bit data bus with 4-bit even parity generated and checked.
// - 20-bit two-way tag bus for address bits 12-31 plus tag valid.
// - 3-bit even tag parity over tag valid concatenated with tag.
// - device drives an 18-bit low byte address bus.
// - each cache read/write enable driven on two identical outputs.
// - instruction and data cache latch clocks toggle every cycle out of reset, held low in reset.
// - dedicated output enables read buffer onto the data bus.
// - 3-bit access type gives size, transfer present and purpose.
// - memory write strobe on main memory write, read strobe on read.
// - run output shows running or stalled, shared with float unit.
// - exception output aborts committing instruction, carries exception info.
// - coprocessor sync clock identical to system output clock.
// - read stall hold normally high; low ends read; sampled only then.
// - write stall hold extends and ends a main memory write stall; the write request starts it.
// - coprocessor stall is float unit stall OR external pin.
// - condition-1 pin outputs float stall, or float interrupt if selected.
// - low address 16/17 are address, condition 2/3, or snoop inputs.
// - in multiprocessor mode snoop hold stalls cache accesses.
// - in multiprocessor mode snoop invalidate drives invalidate data.
// - six interrupt inputs; also mode select; float interrupt line default 3.
// - mode values captured over the last four cycles before release.
module cache_bus_if (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // data bus
  input  wire logic [`DATA_W-1:0]   data_in,
  output logic      [`DATA_W-1:0]   data_out,
  output logic                      data_oe,
  input  wire logic [`DPAR_W-1:0]   data_parity_in,
  output logic      [`DPAR_W-1:0]   data_parity_out,
  output logic                      data_parity_oe,
  // tag bus
  input  wire logic [`TAG_W-1:0]    tag_in,
  output logic      [`TAG_W-1:0]    tag_out,
  output logic                      tag_oe,
  input  wire logic                 tag_valid_in,
  output logic                      tag_valid_out,
  output logic                      tag_valid_oe,
  input  wire logic [`TPAR_W-1:0]   tag_parity_in,
  output logic      [`TPAR_W-1:0]   tag_parity_out,
  output logic                      tag_parity_oe,
  // low address, bits 17:16 multi-function
  output logic      [`LOW_ADDRESS_W-1:0]  low_address,
  output logic      [1:0]           low_address_hi_oe,
  input  wire logic [1:0]           low_address_hi_in,
  // cache strobes
  output logic                      icache_read_en,
  output logic                      icache_read_en_copy,
  output logic                      icache_write_en,
  output logic                      icache_write_en_copy,
  output logic                      dcache_read_en,
  output logic                      dcache_read_en_copy,
  output logic                      dcache_write_en,
  output logic                      dcache_write_en_copy,
  output logic                      icache_latch_clock,
  output logic                      dcache_latch_clock,
  output logic                      read_buffer_en,
  // memory handshake
  output logic      [2:0]           access_type,
  output logic                      mem_write_strobe,
  output logic                      mem_read_strobe,
  input  wire logic                 bus_fault,
  input  wire logic                 read_stall_hold,
  input  wire logic                 write_stall_hold,
  // coprocessor pins
  output logic                      run,
  output logic                      exception,
  output logic                      system_out_clock,
  output logic                      coproc_sync_clock,
  input  wire logic                 coproc_stall,
  input  wire logic                 coproc_condition0,
  output logic                      coproc_condition1,
  input  wire logic [`INT_W-1:0]    int_n,
  // internal float unit
  input  wire logic                 fpu_stall,
  input  wire logic                 fpu_condition,
  input  wire logic                 fpu_interrupt,
  // core request
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic [1:0]           req_kind,
  input  wire logic                 req_icache,
  input  wire logic [1:0]           req_size,
  input  wire logic [31:0]          req_addr,
  input  wire logic [`DATA_W-1:0]   req_wdata,
  input  wire logic                 req_tag_valid,
  // core response
  output logic                      rsp_valid,
  output logic      [`DATA_W-1:0]   rsp_data,
  output logic      [`TAG_W-1:0]    rsp_tag,
  output logic                      rsp_tag_valid,
  output logic                      rsp_fault,
  output logic                      rsp_parity_err,
  output logic                      core_coproc_stall,
  output logic      [3:0]           core_coproc_cond,
  output logic      [`INT_W-1:0]    core_irq,
  // register port
  input  wire logic [1:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata
);

  cache_bus_pkg::st_t q_ff;
  cache_bus_pkg::st_t nxt_q;

  // per byte / per slice even parity
  function automatic logic [`DPAR_W-1:0] dpar(input logic [`DATA_W-1:0] d);
    logic [`DPAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < `DPAR_W; i++) begin
      p[i] = ^d[i*8 +: 8];
    end
    return p;
  endfunction

  function automatic logic [`TPAR_W-1:0] tpar(input logic [`TAG_W:0] t);
    logic [`TPAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < `TPAR_W; i++) begin
      p[i] = ^t[i*`TSLICE_W +: `TSLICE_W];
    end
    return p;
  endfunction

  // decoded views of state
  logic [`DATA_W-1:0] s_data;
  logic [`DPAR_W-1:0] s_dpar;
  logic [`TAG_W-1:0]  s_tag;
  logic               s_tv;
  logic [`TPAR_W-1:0] s_tpar;
  logic               mp;
  logic               adr_dis;
  logic               snp_hold;
  logic               snp_inv;
  logic               perr;
  logic [2:0]         fp_line;
  logic [2:0]         fp_code;

  assign {s_tpar, s_tv, s_tag, s_dpar, s_data} = q_ff.bus_s2;
  assign mp       = q_ff.hist[`M_MP];
  assign adr_dis  = q_ff.hist[`M_ADRDIS];
  assign snp_hold = mp & q_ff.ctl_s2[`CTL_LA_HI];
  assign snp_inv  = mp & q_ff.ctl_s2[`CTL_LA_LO];
  assign fp_code  = {q_ff.hist[`M_FPD2], q_ff.hist[`M_FPD1], q_ff.hist[`M_FPD0]};
  assign fp_line  = (fp_code > `FPU_INTERRUPT_MAXL) ? `FPU_INTERRUPT_DFLT : fp_code;
  // parity check on data, and on tag for cache reads
  assign perr = q_ff.ctrl_par & ~q_ff.hist[`M_NOPAR] &
                ((dpar(s_data) != s_dpar) |
                 ((q_ff.r_kind == cache_bus_pkg::K_CRD) &
                  (tpar({s_tv, s_tag}) != s_tpar)));

  // next state
  always_comb begin
    nxt_q = q_ff;
    // pin synchronisers; only the interrupt pair keeps running in reset
    nxt_q.bus_s1 = {tag_parity_in, tag_valid_in, tag_in, data_parity_in, data_in};
    nxt_q.bus_s2 = q_ff.bus_s1;
    nxt_q.ctl_s1 = {read_stall_hold, write_stall_hold, bus_fault, coproc_stall,
                    coproc_condition0, low_address_hi_in, 6'h00};
    nxt_q.ctl_s2 = q_ff.ctl_s1;
    nxt_q.int_s1 = int_n;
    nxt_q.int_s2 = q_ff.int_s1;
    // free running clocks, held low only in reset
    nxt_q.lclk = ~q_ff.lclk;
    nxt_q.sclk = ~q_ff.sclk;
    // one-cycle pulses
    nxt_q.rsp_v = 1'b0;
    nxt_q.exc   = 1'b0;
    nxt_q.mwr   = 1'b0;
    nxt_q.rdata = 32'h0;
    // pin functions from captured mode
    nxt_q.la_oe = {2{~(mp | adr_dis)}};
    nxt_q.cp_stall = fpu_stall | q_ff.ctl_s2[`CTL_CPS];
    nxt_q.cp_cond = {adr_dis & ~mp & q_ff.ctl_s2[`CTL_LA_HI],
                     adr_dis & ~mp & q_ff.ctl_s2[`CTL_LA_LO],
                     fpu_condition, q_ff.ctl_s2[`CTL_CC0]};
    nxt_q.cond1 = q_ff.hist[`M_FPU_CONDITION] ? fpu_interrupt : fpu_stall;
    nxt_q.irq = ~q_ff.int_s2;
    if (!q_ff.hist[`M_FPU_CONDITION] && fpu_interrupt) begin
      nxt_q.irq[fp_line] = 1'b1;
    end
    // register writes; hardware set beats W1C clear
    if (reg_wr && reg_addr == `REG_CTRL) begin
      nxt_q.ctrl_par = reg_wdata[0];
    end
    if (reg_wr && reg_addr == `REG_STATUS) begin
      nxt_q.st_flt  = q_ff.st_flt & ~reg_wdata[0];
      nxt_q.st_perr = q_ff.st_perr & ~reg_wdata[1];
    end
    // register reads, data in next cycle
    if (reg_rd) begin
      unique case (reg_addr)
        `REG_CTRL:   nxt_q.rdata = {31'h0, q_ff.ctrl_par};
        `REG_STATUS: nxt_q.rdata = {27'h0, snp_hold, mp,
                                    q_ff.st != cache_bus_pkg::ST_IDLE,
                                    q_ff.st_perr, q_ff.st_flt};
        `REG_MODE:   nxt_q.rdata = {8'h00, q_ff.hist};
        default:     nxt_q.rdata = 32'h0;
      endcase
    end
    // transfer sequencer
    unique case (q_ff.st)
      cache_bus_pkg::ST_IDLE: begin
        nxt_q.run = ~snp_hold & ~q_ff.cp_stall;
        nxt_q.ready = ~snp_hold & ~snp_inv;
        if (snp_inv) begin
          // invalidate entry at externally supplied address
          nxt_q.st      = cache_bus_pkg::ST_INV;
          nxt_q.ready   = 1'b0;
          nxt_q.tag_out = '0;
          nxt_q.tv_out  = 1'b0;
          nxt_q.tpar_out = tpar({1'b0, {`TAG_W{1'b0}}});
          nxt_q.tag_oe  = 1'b1;
          nxt_q.dc_wr   = 1'b1;
          nxt_q.acc     = cache_bus_pkg::AT_INVAL;
        end else if (req_valid && q_ff.ready) begin
          nxt_q.ready   = 1'b0;
          nxt_q.r_kind  = cache_bus_pkg::kind_t'(req_kind);
          nxt_q.r_ic    = req_icache;
          nxt_q.r_size  = req_size;
          nxt_q.r_addr  = req_addr;
          nxt_q.r_wdata = req_wdata;
          nxt_q.r_tv    = req_tag_valid;
          nxt_q.cnt     = 3'h0;
          nxt_q.la_out  = req_addr[`LOW_ADDRESS_W-1:0];
          nxt_q.tag_out = req_addr[31:12];
          nxt_q.tv_out  = req_tag_valid;
          nxt_q.tpar_out = tpar({req_tag_valid, req_addr[31:12]});
          nxt_q.tag_oe  = req_kind != cache_bus_pkg::K_CRD;
          nxt_q.data_out = req_wdata;
          nxt_q.dpar_out = dpar(req_wdata);
          nxt_q.data_oe = req_kind[0];
          nxt_q.acc = req_icache ? cache_bus_pkg::AT_FETCH :
                      cache_bus_pkg::acc_t'({1'b0, req_size} + 3'h1);
          unique case (cache_bus_pkg::kind_t'(req_kind))
            cache_bus_pkg::K_CRD: begin
              nxt_q.st    = cache_bus_pkg::ST_CACHE;
              nxt_q.ic_rd = req_icache;
              nxt_q.dc_rd = ~req_icache;
            end
            cache_bus_pkg::K_CWR: begin
              nxt_q.st    = cache_bus_pkg::ST_CACHE;
              nxt_q.ic_wr = req_icache;
              nxt_q.dc_wr = ~req_icache;
            end
            cache_bus_pkg::K_MRD: begin
              nxt_q.st      = cache_bus_pkg::ST_MRD;
              nxt_q.mrd     = 1'b1;
              nxt_q.rbuf_en = 1'b1;
              nxt_q.run     = 1'b0;
            end
            cache_bus_pkg::K_MWR: begin
              nxt_q.st  = cache_bus_pkg::ST_MWR;
              nxt_q.mwr = 1'b1;
              nxt_q.run = 1'b0;
            end
          endcase
        end
      end
      cache_bus_pkg::ST_CACHE: begin
        nxt_q.cnt = q_ff.cnt + 3'h1;
        if (q_ff.cnt == `CACHE_WAIT) begin
          nxt_q.st = cache_bus_pkg::ST_IDLE;
          nxt_q.rsp_v = 1'b1;
          nxt_q.rsp_flt = 1'b0;
          nxt_q.rsp_data = s_data;
          nxt_q.rsp_tag = s_tag;
          nxt_q.rsp_tv = s_tv;
          nxt_q.rsp_perr = (q_ff.r_kind == cache_bus_pkg::K_CRD) & perr;
          nxt_q.exc = (q_ff.r_kind == cache_bus_pkg::K_CRD) & perr;
          nxt_q.st_perr = nxt_q.st_perr | nxt_q.rsp_perr;
          {nxt_q.ic_rd, nxt_q.ic_wr, nxt_q.dc_rd, nxt_q.dc_wr} = 4'h0;
          nxt_q.tag_oe = 1'b0;
          nxt_q.data_oe = 1'b0;
          nxt_q.acc = cache_bus_pkg::AT_NONE;
          nxt_q.ready = 1'b1;
        end
      end
      cache_bus_pkg::ST_MRD: begin
        // hold sampled only in this stall
        if (q_ff.ctl_s2[`CTL_FLT] || !q_ff.ctl_s2[`CTL_RDH]) begin
          nxt_q.st = cache_bus_pkg::ST_IDLE;
          nxt_q.mrd = 1'b0;
          nxt_q.rbuf_en = 1'b0;
          nxt_q.tag_oe = 1'b0;
          nxt_q.acc = cache_bus_pkg::AT_NONE;
          nxt_q.rsp_v = 1'b1;
          nxt_q.rsp_data = s_data;
          nxt_q.rsp_tag = q_ff.r_addr[31:12];
          nxt_q.rsp_tv = 1'b1;
          nxt_q.rsp_flt = q_ff.ctl_s2[`CTL_FLT];
          nxt_q.rsp_perr = ~q_ff.ctl_s2[`CTL_FLT] & perr;
          nxt_q.exc = q_ff.ctl_s2[`CTL_FLT] | perr;
          nxt_q.st_flt = nxt_q.st_flt | q_ff.ctl_s2[`CTL_FLT];
          nxt_q.st_perr = nxt_q.st_perr | nxt_q.rsp_perr;
          nxt_q.ready = 1'b1;
        end
      end
      cache_bus_pkg::ST_MWR: begin
        // wait for the hold to reach the synchronised copy
        nxt_q.cnt = q_ff.cnt + 3'h1;
        if (q_ff.cnt == `CACHE_WAIT) begin
          nxt_q.st = cache_bus_pkg::ST_WSTL;
        end
      end
      cache_bus_pkg::ST_WSTL: begin
        if (q_ff.ctl_s2[`CTL_FLT] || !q_ff.ctl_s2[`CTL_WRH]) begin
          nxt_q.st = cache_bus_pkg::ST_IDLE;
          nxt_q.data_oe = 1'b0;
          nxt_q.tag_oe = 1'b0;
          nxt_q.acc = cache_bus_pkg::AT_NONE;
          nxt_q.rsp_v = 1'b1;
          nxt_q.rsp_flt = q_ff.ctl_s2[`CTL_FLT];
          nxt_q.rsp_perr = 1'b0;
          nxt_q.exc = q_ff.ctl_s2[`CTL_FLT];
          nxt_q.st_flt = nxt_q.st_flt | q_ff.ctl_s2[`CTL_FLT];
          nxt_q.ready = 1'b1;
        end
      end
      cache_bus_pkg::ST_INV: begin
        nxt_q.st = cache_bus_pkg::ST_IDLE;
        nxt_q.dc_wr = 1'b0;
        nxt_q.tag_oe = 1'b0;
        nxt_q.acc = cache_bus_pkg::AT_NONE;
      end
      default: nxt_q.st = cache_bus_pkg::ST_IDLE;
    endcase
    if (sys_rst) begin
      // reset: outputs to idle, mode history keeps shifting
      nxt_q = '0;
      nxt_q.bus_s1 = q_ff.bus_s1;
      nxt_q.bus_s2 = q_ff.bus_s2;
      nxt_q.ctl_s1 = q_ff.ctl_s1;
      nxt_q.ctl_s2 = q_ff.ctl_s2;
      nxt_q.int_s1 = int_n;
      nxt_q.int_s2 = q_ff.int_s1;
      nxt_q.hist = {q_ff.hist[`MODE_W-`INT_W-1:0], q_ff.int_s2};
      nxt_q.ctrl_par = `CTRL_RST;
      nxt_q.st = cache_bus_pkg::ST_IDLE;
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    q_ff <= nxt_q;
  end

  // pin outputs straight from state
  assign data_out             = q_ff.data_out;
  assign data_oe              = q_ff.data_oe;
  assign data_parity_out      = q_ff.dpar_out;
  assign data_parity_oe       = q_ff.data_oe;
  assign tag_out              = q_ff.tag_out;
  assign tag_oe               = q_ff.tag_oe;
  assign tag_valid_out        = q_ff.tv_out;
  assign tag_valid_oe         = q_ff.tag_oe;
  assign tag_parity_out       = q_ff.tpar_out;
  assign tag_parity_oe        = q_ff.tag_oe;
  assign low_address          = q_ff.la_out;
  assign low_address_hi_oe    = q_ff.la_oe;
  assign icache_read_en       = q_ff.ic_rd;
  assign icache_read_en_copy  = q_ff.ic_rd;
  assign icache_write_en      = q_ff.ic_wr;
  assign icache_write_en_copy = q_ff.ic_wr;
  assign dcache_read_en       = q_ff.dc_rd;
  assign dcache_read_en_copy  = q_ff.dc_rd;
  assign dcache_write_en      = q_ff.dc_wr;
  assign dcache_write_en_copy = q_ff.dc_wr;
  assign icache_latch_clock   = q_ff.lclk;
  assign dcache_latch_clock   = q_ff.lclk;
  assign read_buffer_en       = q_ff.rbuf_en;
  assign access_type          = q_ff.acc;
  assign mem_write_strobe     = q_ff.mwr;
  assign mem_read_strobe      = q_ff.mrd;
  assign run                  = q_ff.run;
  assign exception            = q_ff.exc;
  assign system_out_clock     = q_ff.sclk;
  assign coproc_sync_clock    = q_ff.sclk;
  assign coproc_condition1    = q_ff.cond1;
  assign req_ready            = q_ff.ready;
  assign rsp_valid            = q_ff.rsp_v;
  assign rsp_data             = q_ff.rsp_data;
  assign rsp_tag              = q_ff.rsp_tag;
  assign rsp_tag_valid        = q_ff.rsp_tv;
  assign rsp_fault            = q_ff.rsp_flt;
  assign rsp_parity_err       = q_ff.rsp_perr;
  assign core_coproc_stall    = q_ff.cp_stall;
  assign core_coproc_cond     = q_ff.cp_cond;
  assign core_irq             = q_ff.irq;
  assign reg_rdata            = q_ff.rdata;

endmodule

// file: src/cache_bus_params.svh
`ifndef CACHE_BUS_PARAMS_SVH
`define CACHE_BUS_PARAMS_SVH
// bus widths
`define DATA_W      32
`define DPAR_W      4
`define TAG_W       20
`define TPAR_W      3
`define TSLICE_W    7
`define LOW_ADDRESS_W     18
`define INT_W       6
`define MODE_W      24
// synchronised bus fields {tpar,tv,tag,dpar,data}
`define BUS_W       60
`define CTL_W       13
`define CTL_RDH     12
`define CTL_WRH     11
`define CTL_FLT     10
`define CTL_CPS     9
`define CTL_CC0     8
`define CTL_LA_HI   7
`define CTL_LA_LO   6
// mode history bit positions (W oldest .. Z newest)
`define M_MP        9
`define M_ADRDIS    7
`define M_NOPAR     8
`define M_FPU_CONDITION    4
`define M_FPD2      22
`define M_FPD1      16
`define M_FPD0      10
`define FPU_INTERRUPT_DFLT  3'h3
`define FPU_INTERRUPT_MAXL  3'h5
// cycles from cache enable to sampled read data
`define CACHE_WAIT  3'h3
// register port
`define REG_CTRL    2'h0
`define REG_STATUS  2'h1
`define REG_MODE    2'h2
`define CTRL_RST    1'h1
`endif

// file: src/cache_bus_pkg.sv
package cache_bus_pkg;
  `include "cache_bus_params.svh"

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CACHE = 3'b001,
    ST_MRD   = 3'b010,
    ST_MWR   = 3'b011,
    ST_WSTL  = 3'b100,
    ST_INV   = 3'b101
  } state_t;

  typedef enum logic [1:0] {
    K_CRD = 2'b00,
    K_CWR = 2'b01,
    K_MRD = 2'b10,
    K_MWR = 2'b11
  } kind_t;

  typedef enum logic [2:0] {
    AT_NONE  = 3'b000,
    AT_BYTE  = 3'b001,
    AT_HALF  = 3'b010,
    AT_TRI   = 3'b011,
    AT_WORD  = 3'b100,
    AT_FETCH = 3'b101,
    AT_INVAL = 3'b110
  } acc_t;

  typedef struct packed {
    state_t              st;
    logic [2:0]          cnt;
    logic [`BUS_W-1:0]   bus_s1;
    logic [`BUS_W-1:0]   bus_s2;
    logic [`CTL_W-1:0]   ctl_s1;
    logic [`CTL_W-1:0]   ctl_s2;
    logic [`INT_W-1:0]   int_s1;
    logic [`INT_W-1:0]   int_s2;
    logic [`MODE_W-1:0]  hist;
    kind_t               r_kind;
    logic                r_ic;
    logic [1:0]          r_size;
    logic [31:0]         r_addr;
    logic [`DATA_W-1:0]  r_wdata;
    logic                r_tv;
    logic [`DATA_W-1:0]  data_out;
    logic [`DPAR_W-1:0]  dpar_out;
    logic                data_oe;
    logic [`TAG_W-1:0]   tag_out;
    logic                tv_out;
    logic [`TPAR_W-1:0]  tpar_out;
    logic                tag_oe;
    logic [`LOW_ADDRESS_W-1:0] la_out;
    logic [1:0]          la_oe;
    logic                ic_rd;
    logic                ic_wr;
    logic                dc_rd;
    logic                dc_wr;
    logic                lclk;
    logic                sclk;
    logic                rbuf_en;
    acc_t                acc;
    logic                mwr;
    logic                mrd;
    logic                run;
    logic                exc;
    logic                cond1;
    logic [`INT_W-1:0]   irq;
    logic                cp_stall;
    logic [3:0]          cp_cond;
    logic                ready;
    logic                rsp_v;
    logic [`DATA_W-1:0]  rsp_data;
    logic [`TAG_W-1:0]   rsp_tag;
    logic                rsp_tv;
    logic                rsp_flt;
    logic                rsp_perr;
    logic                ctrl_par;
    logic                st_flt;
    logic                st_perr;
    logic [31:0]         rdata;
  } st_t;
endpackage

// file: src/cache_bus_dummy_unused.sv
`timescale 1ns/1ps

// file: verification/cache_bus_monitor.sv
`timescale 1ns/1ps
module cache_bus_monitor (
  // clock and reset
  input wire logic        clk_sys, sys_rst,
  // buses
  input wire logic [31:0] data_out,
  input wire logic [3:0]  data_parity_out,
  input wire logic [19:0] tag_out,
  input wire logic [2:0]  tag_parity_out,
  // single pins
  input wire logic        data_oe, tag_oe, tag_valid_out, icache_read_en, icache_read_en_copy,
  input wire logic        dcache_read_en, dcache_write_en, dcache_write_en_copy,
  input wire logic        icache_latch_clock, dcache_latch_clock, system_out_clock,
  input wire logic        coproc_sync_clock, run, mem_write_strobe, mem_read_strobe,
  input wire logic        read_buffer_en, fpu_stall, core_coproc_stall
);
  wire [20:0] tw = {tag_valid_out, tag_out};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // split enables and free running clocks
  copy_ird_a: assert property (icache_read_en == icache_read_en_copy)
    else $error("icache enable copy differs");
  copy_dwr_a: assert property (dcache_write_en == dcache_write_en_copy)
    else $error("dcache enable copy differs");
  clk_run_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
    $changed(icache_latch_clock) && $changed(dcache_latch_clock)) else $error("latch clock stuck");
  sync_clk_a: assert property (coproc_sync_clock == system_out_clock)
    else $error("sync clock differs");
  // parity while driving
  dpar_a: assert property (data_oe |-> data_parity_out ==
    {^data_out[31:24], ^data_out[23:16], ^data_out[15:8], ^data_out[7:0]})
    else $error("bad data parity");
  tpar_a: assert property (tag_oe |-> tag_parity_out ==
    {^tw[20:14], ^tw[13:7], ^tw[6:0]}) else $error("bad tag parity");
  // memory strobes and stalls
  wr_pulse_a: assert property (mem_write_strobe |=> !mem_write_strobe)
    else $error("write strobe too long");
  rd_stall_a: assert property (mem_read_strobe |-> read_buffer_en && !run)
    else $error("read stall pins wrong");
  cp_stall_a: assert property (fpu_stall && !$past(sys_rst) |=> core_coproc_stall)
    else $error("float stall not merged");
  // main scenarios
  cover property (mem_read_strobe ##1 !mem_read_strobe);
  cover property (mem_write_strobe);
  cover property (dcache_read_en);
endmodule

// file: verification/cache_bus_mem_model.sv
`timescale 1ns/1ps
module cache_bus_mem_model #(
  parameter logic [31:0] RD_WORD = 32'h1234abcd,
  parameter logic [19:0] RD_TAG  = 20'h5a5a5
) (
  // clock and scenario controls
  input wire logic        clk_sys, fault_on,
  input wire logic [3:0]  dly,
  // device strobes
  input wire logic        mem_read_strobe, mem_write_strobe, rd_en,
  // pins driven toward the device
  output logic     [31:0] md,
  output logic     [3:0]  mdp,
  output logic     [19:0] mt,
  output logic     [2:0]  mtp,
  output logic            mtv, read_stall_hold, write_stall_hold, bus_fault
);
  logic [3:0] cnt = 4'h0;
  logic       wr  = 1'b0;
  wire        srv = mem_read_strobe | rd_en;
  // wait counter and write stall flag
  always_ff @(posedge clk_sys) begin
    cnt <= (mem_read_strobe | wr) ? cnt + 4'h1 : 4'h0;
    if (mem_write_strobe) wr <= 1'b1;
    else if (cnt >= dly) wr <= 1'b0;
  end
  // handshake pins; released buses show the inverse
  assign read_stall_hold  = !(mem_read_strobe && cnt >= dly && !fault_on);
  assign write_stall_hold = wr;
  assign bus_fault = fault_on && mem_read_strobe && cnt >= dly;
  assign md  = srv ? RD_WORD : ~RD_WORD;
  assign mdp = {^md[31:24], ^md[23:16], ^md[15:8], ^md[7:0]};
  assign mt  = srv ? RD_TAG : ~RD_TAG;
  assign mtv = srv;
  assign mtp = {^{mtv, mt[19:14]}, ^mt[13:7], ^mt[6:0]};
endmodule

// file: verification/test_cache_bus_if.sv
`timescale 1ns/1ps
module test_cache_bus_if;
  typedef struct {logic [1:0] k, sz; logic [31:0] a; logic [2:0] at;} row_t;
  localparam logic [31:0] rd_word = 32'h1234abcd;
  localparam logic [19:0] rd_tag  = 20'h5a5a5;
  logic clk_sys = 1'b0, sys_rst = 1'b1, fault_on = 1'b0, req_valid = 1'b0, req_icache = 1'b0;
  logic [31:0] data_in, data_out, req_addr, req_wdata, reg_wdata, reg_rdata, rsp_data, md;
  logic [3:0] data_parity_in, data_parity_out, mdp, core_coproc_cond, dly = 4'h0;
  logic [19:0] tag_in, tag_out, rsp_tag, mt;
  logic [2:0] tag_parity_in, tag_parity_out, mtp, access_type;
  logic [17:0] low_address;
  logic [5:0] int_n = 6'h08, core_irq;
  logic [1:0] low_address_hi_oe, low_address_hi_in = 2'h0, req_kind, req_size, reg_addr = 2'h0;
  logic data_oe, data_parity_oe, tag_oe, tag_valid_in, tag_valid_out, tag_valid_oe, mtv;
  logic tag_parity_oe, icache_read_en, icache_read_en_copy, icache_write_en, icache_write_en_copy;
  logic dcache_read_en, dcache_read_en_copy, dcache_write_en, dcache_write_en_copy, run;
  logic icache_latch_clock, dcache_latch_clock, read_buffer_en, mem_write_strobe, mem_read_strobe;
  logic bus_fault, read_stall_hold, write_stall_hold, exception, system_out_clock;
  logic coproc_sync_clock, coproc_stall = 1'b0, coproc_condition0 = 1'b0, coproc_condition1;
  logic fpu_stall = 1'b0, fpu_condition = 1'b0, fpu_interrupt = 1'b0, req_tag_valid = 1'b1;
  logic req_ready, rsp_valid, rsp_tag_valid, rsp_fault, rsp_parity_err, core_coproc_stall;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  int fail_count = 0, tests_run = 0;
  row_t rows[5] = '{'{2'h0, 2'h0, 32'h00021004, 3'h1}, '{2'h1, 2'h1, 32'h00032008, 3'h2},
    '{2'h2, 2'h2, 32'h00003ffc, 3'h3}, '{2'h3, 2'h3, 32'h00014000, 3'h4},
    '{2'h2, 2'h3, 32'hfffc0004, 3'h4}};
  // clock and shared bus wires, device wins while it drives
  always #12.5 clk_sys = ~clk_sys;
  assign data_in = data_oe ? data_out : md;
  assign data_parity_in = data_oe ? data_parity_out : mdp;
  assign tag_in = tag_oe ? tag_out : mt;
  assign tag_valid_in = tag_oe ? tag_valid_out : mtv;
  assign tag_parity_in = tag_oe ? tag_parity_out : mtp;
  cache_bus_if dut (.*);
  cache_bus_mem_model mem (.clk_sys, .fault_on, .dly, .mem_read_strobe, .mem_write_strobe,
    .rd_en(icache_read_en | dcache_read_en), .md, .mdp, .mt, .mtp, .mtv, .read_stall_hold,
    .write_stall_hold, .bus_fault);
  // comparison and closing
  task automatic chk(input logic [63:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d, bad %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // register port cycle, read data checked in the following cycle
  task automatic reg_op(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge clk_sys);
    {reg_wr, reg_rd} <= 2'b00;
    #1;
  endtask
  // one core request through to its response
  task automatic op(input logic [1:0] k, sz, input logic [31:0] a, input logic [2:0] at_x,
                    input logic [3:0] d, input logic f);
    int n = 0;
    logic [20:0] seen = '0;
    @(posedge clk_sys);
    {req_valid, req_kind, req_size, req_addr, req_wdata, dly, fault_on} <= {1'b1, k, sz, a, ~a, d, f};
    do @(negedge clk_sys); while (req_ready !== 1'b1);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
      if (mem_read_strobe | mem_write_strobe) seen = {access_type, low_address};
    end while (rsp_valid !== 1'b1 && n < 60);
    chk(n < 60, 1);
    if (k[1]) chk(seen, {at_x, a[17:0]});
    if (!k[0] && !f) chk({rsp_data, rsp_parity_err}, {rd_word, 1'b0});
    if (k == 2'h0) chk({rsp_tag, rsp_tag_valid}, {rd_tag, 1'b1});
    chk(rsp_fault, f);
  endtask
  // hang guard
  initial begin
    #100000;
    fail_count++;
    report_and_stop;
  end
  // main sequence
  initial begin
    {req_kind, req_size, req_addr, req_wdata, reg_wdata} = '0;
    repeat (3) @(posedge clk_sys);
    #1 chk({req_ready, mem_read_strobe, system_out_clock}, 0);
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    foreach (rows[i]) op(rows[i].k, rows[i].sz, rows[i].a, rows[i].at, 4'(2 * i), 1'b0);
    // failed read, sticky status, clear, mode and unmapped readback
    op(2'h2, 2'h2, 32'h00000100, 3'h3, 4'h9, 1'b1);
    reg_op(1'b0, 2'h1, 32'h0);
    chk(reg_rdata, 32'h9);
    reg_op(1'b1, 2'h1, 32'h1);
    reg_op(1'b0, 2'h1, 32'h0);
    chk(reg_rdata, 32'h8);
    reg_op(1'b0, 2'h2, 32'h0);
    chk(reg_rdata, 32'h208208);
    reg_op(1'b1, 2'h3, 32'hffffffff);
    reg_op(1'b0, 2'h3, 32'h0);
    chk(reg_rdata, 32'h0);
    // float stall reaches merged stall, condition pin and run
    @(posedge clk_sys);
    fpu_stall <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk({core_coproc_stall, coproc_condition1, run}, 3'b110);
    @(posedge clk_sys);
    fpu_stall <= 1'b0;
    low_address_hi_in <= 2'h2;
    repeat (5) @(posedge clk_sys);
    #1 chk({req_ready, run}, 0);
    @(posedge clk_sys);
    low_address_hi_in <= 2'h0;
    op(2'h3, 2'h0, 32'h0003fff0, 3'h1, 4'h0, 1'b0);
    report_and_stop;
  end
endmodule
bind cache_bus_if cache_bus_monitor mon (.*);
